/* File: rtc_irq_output.sv */
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
module rtc_irq_output
    import rtc_irq_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    // time base
    input wire logic compareStrobe,
    input wire logic otherFieldsMatch,
    input wire logic [5:0] currentDate,
    input wire logic watchdogTimeout,
    // interrupt pin
    output logic intPinOut,
    output logic intPinOe,
    // system interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bus_state_t busState_r;
    bus_state_t busState_nxt;
    logic [DATA_W-1:0] readData_r;
    logic [DATA_W-1:0] readData_nxt;
    alarm_date_t alarmDate_r;
    alarm_date_t alarmDate_nxt;
    int_ctrl_t ctrl_r;
    int_ctrl_t ctrl_nxt;
    logic [1:0] flags_r;
    logic [1:0] flags_nxt;
    logic [1:0] irqStatus_r;
    logic [1:0] irqStatus_nxt;
    logic [1:0] irqMask_r;
    logic [1:0] irqMask_nxt;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire selDate = (address == ADDR_ALARM_DATE);
    wire selCtrl = (address == ADDR_INT_CONTROL);
    wire selFlags = (address == ADDR_FLAGS);
    wire selStatus = (address == ADDR_IRQ_STATUS);
    wire selMask = (address == ADDR_IRQ_MASK);
    // only the low lane carries register bits
    wire wrLow = write && byteenable[0];
    wire wrDate = wrLow && selDate;
    wire wrCtrl = wrLow && selCtrl;
    wire wrFlags = wrLow && selFlags;
    wire wrStatus = wrLow && selStatus;
    wire wrMask = wrLow && selMask;
    // read accepted on the edge where waitrequest is low
    wire readAccept = read && (busState_r == BUS_READ_ACK);
    wire flagsRead = readAccept && selFlags;

    // writes never wait; reads wait one cycle for registered data
    assign waitrequest = read && (busState_r == BUS_IDLE);

    // ----------------------------------------------------------------
    // bus state machine
    // ----------------------------------------------------------------
    always_comb begin
        busState_nxt = BUS_IDLE;
        case (busState_r)
            BUS_IDLE: begin
                if (read) begin
                    busState_nxt = BUS_READ_ACK;
                end
            end
            BUS_READ_ACK: begin
                // ack lasts one cycle; a read still high starts a new access
                busState_nxt = BUS_IDLE;
            end
            default: begin
                busState_nxt = BUS_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] dateView = {alarmDate_r.ignore, 1'b0, alarmDate_r.tens, alarmDate_r.units};
    wire [7:0] ctrlView = {ctrl_r.wdIrqEn, ctrl_r.alarmIrqEn, 2'b00,
                           ctrl_r.polarityHigh, ctrl_r.pulseMode, 2'b00};
    wire [7:0] flagsView = {flags_r[EVT_WATCHDOG_BIT], flags_r[EVT_ALARM_BIT], 6'h00};
    logic [7:0] readSel;
    always_comb begin
        if (selDate) begin
            readSel = dateView;
        end else if (selCtrl) begin
            readSel = ctrlView;
        end else if (selFlags) begin
            readSel = flagsView;
        end else if (selStatus) begin
            readSel = {6'h00, irqStatus_r};
        end else if (selMask) begin
            readSel = {6'h00, irqMask_r};
        end else begin
            // unmapped reads return zero
            readSel = 8'h00;
        end
    end
    assign readData_nxt = (read && busState_r == BUS_IDLE) ? {24'h00_0000, readSel} : readData_r;
    assign readdata = readData_r;

    // ----------------------------------------------------------------
    // alarm compare
    // ----------------------------------------------------------------
    // date match or ignored
    wire dateEqual = ({alarmDate_r.tens, alarmDate_r.units} == currentDate);
    wire dateOk = alarmDate_r.ignore || dateEqual;
    // strobe gates the compare so a standing match fires once
    wire alarmMatch = compareStrobe && otherFieldsMatch && dateOk;

    assign alarmDate_nxt = wrDate ? alarm_date_t'({writedata[DATE_IGNORE_BIT], writedata[5:0]})
                                  : alarmDate_r;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    assign ctrl_nxt = wrCtrl ? int_ctrl_t'({writedata[CTRL_WD_IRQ_EN_BIT],
                                            writedata[CTRL_ALARM_IRQ_EN_BIT],
                                            writedata[CTRL_POLARITY_BIT],
                                            writedata[CTRL_PULSE_BIT]}) : ctrl_r;

    // ----------------------------------------------------------------
    // events, flags and pin trigger
    // ----------------------------------------------------------------
    wire [1:0] events = {watchdogTimeout, alarmMatch};
    wire [1:0] srcEnable = {ctrl_r.wdIrqEn, ctrl_r.alarmIrqEn};
    wire [1:0] flagsClear = wrFlags ? {writedata[FLAG_WATCHDOG_BIT],
                                       writedata[FLAG_ALARM_BIT]} : 2'b00;
    wire [1:0] statusClear = wrStatus ? writedata[1:0] : 2'b00;
    logic [1:0] srcTrigger;

    // ----------------------------------------------------------------
    // per-source sticky bits and pin trigger
    // ----------------------------------------------------------------
    // one slice per source: bit 0 alarm, bit 1 watchdog
    for (genvar src = 0; src < 2; src++) begin : gSource
        // both flags always set, even with the source disabled
        // set wins over a clear in the same cycle
        assign flags_nxt[src] = (flags_r[src] && !flagsClear[src]) || events[src];
        assign irqStatus_nxt[src] = (irqStatus_r[src] && !statusClear[src]) || events[src];
        assign srcTrigger[src] = events[src] && srcEnable[src];
    end

    // any enabled source fires the pin
    wire pinTrigger = |srcTrigger;

    // ----------------------------------------------------------------
    // system interrupt
    // ----------------------------------------------------------------
    assign irqMask_nxt = wrMask ? writedata[1:0] : irqMask_r;
    // combinational from flops, so no extra cycle of latency
    assign irq = |(irqStatus_r & irqMask_r);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // one flop bank; date, flag, status and mask reset values come from the package
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busState_r <= BUS_IDLE;
            readData_r <= '0;
            alarmDate_r <= alarm_date_t'({ALARM_DATE_RESET[DATE_IGNORE_BIT],
                                          ALARM_DATE_RESET[5:0]});
            ctrl_r <= '0;
            flags_r <= EVT_RESET;
            irqStatus_r <= EVT_RESET;
            irqMask_r <= EVT_RESET;
        end else begin
            busState_r <= busState_nxt;
            readData_r <= readData_nxt;
            alarmDate_r <= alarmDate_nxt;
            ctrl_r <= ctrl_nxt;
            flags_r <= flags_nxt;
            irqStatus_r <= irqStatus_nxt;
            irqMask_r <= irqMask_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pin driver
    // ----------------------------------------------------------------
    // flags read releases pin in level mode; a timed pulse runs out on its own
    int_pin_driver #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) pinDriver (
        .core_clk(core_clk),
        .resetn(resetn),
        .trigger(pinTrigger),
        .holdRelease(flagsRead),
        .pulseMode(ctrl_r.pulseMode),
        .polarityHigh(ctrl_r.polarityHigh),
        .intOut(intPinOut),
        .intOe(intPinOe),
        .intActive()
    );

endmodule : rtc_irq_output

/* File: rtc_irq_pkg.sv */
package rtc_irq_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 21;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // register indices and byte addresses (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [19:0] IDX_ALARM_DATE = 20'h7_fff5;
    localparam logic [19:0] IDX_INT_CONTROL = 20'h7_fff6;
    localparam logic [19:0] IDX_FLAGS = 20'h7_fff0;
    localparam logic [19:0] IDX_IRQ_STATUS = 20'h7_ff00;
    localparam logic [19:0] IDX_IRQ_MASK = 20'h7_ff01;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_DATE = {IDX_ALARM_DATE[18:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_INT_CONTROL = {IDX_INT_CONTROL[18:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS[18:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[18:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[18:0], 2'b00};

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DATE_IGNORE_BIT = 7;
    localparam int CTRL_WD_IRQ_EN_BIT = 7;
    localparam int CTRL_ALARM_IRQ_EN_BIT = 6;
    localparam int CTRL_POLARITY_BIT = 3;
    localparam int CTRL_PULSE_BIT = 2;
    localparam int FLAG_WATCHDOG_BIT = 7;
    localparam int FLAG_ALARM_BIT = 6;
    localparam int EVT_ALARM_BIT = 0;
    localparam int EVT_WATCHDOG_BIT = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ALARM_DATE_RESET = 8'h80;
    localparam logic [1:0] EVT_RESET = 2'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int PULSE_TIME_MS = 200;
    localparam int PULSE_CYCLES_DEF = PULSE_TIME_MS * (CLK_HZ / 1000);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wdIrqEn;
        logic alarmIrqEn;
        logic polarityHigh;
        logic pulseMode;
    } int_ctrl_t;

    typedef struct packed {
        logic ignore;
        logic [1:0] tens;
        logic [3:0] units;
    } alarm_date_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_READ_ACK = 1'b1
    } bus_state_t;

endpackage : rtc_irq_pkg

/* File: int_pin_driver.sv */
`timescale 1ns/1ns
module int_pin_driver
    import rtc_irq_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic trigger,
    input wire logic holdRelease,
    input wire logic pulseMode,
    input wire logic polarityHigh,
    output logic intOut,
    output logic intOe,
    output logic intActive
);

    localparam int CW = $clog2(PULSE_CYCLES + 1);
    localparam logic [CW-1:0] PULSE_LOAD = CW'(PULSE_CYCLES);

    logic [CW-1:0] pulseCount_r;
    logic [CW-1:0] pulseCount_nxt;
    logic held_r;
    logic held_nxt;

    // ----------------------------------------------------------------
    // pulse timer and level latch
    // ----------------------------------------------------------------
    // timed pulse
    assign pulseCount_nxt = (trigger && pulseMode) ? PULSE_LOAD :
                            (pulseCount_r != '0) ? pulseCount_r - CW'(1) : pulseCount_r;
    // hold until release
    // new event beats a release in the same cycle
    assign held_nxt = (trigger && !pulseMode) ? 1'b1 :
                      (holdRelease || pulseMode) ? 1'b0 : held_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pulseCount_r <= '0;
            held_r <= 1'b0;
        end else begin
            pulseCount_r <= pulseCount_nxt;
            held_r <= held_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    assign intActive = pulseMode ? (pulseCount_r != '0) : held_r;
    assign intOut = polarityHigh ? intActive : 1'b0;
    assign intOe = polarityHigh ? 1'b1 : intActive;

endmodule : int_pin_driver

/* File: rtc_irq_output_sva.sv */
`timescale 1ns/1ns
module rtc_irq_output_sva
    import rtc_irq_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic waitrequest,
    input wire logic compareStrobe,
    input wire logic otherFieldsMatch,
    input wire logic [5:0] currentDate,
    input wire logic watchdogTimeout,
    input wire logic intPinOut,
    input wire logic intPinOe
);
    // ------------------------------------------------
    // shadow of control and date, snooped off the bus
    // ------------------------------------------------
    logic [7:0] ctrlR;
    logic [7:0] dateR;
    logic [7:0] quietR;
    wire wrOk = write && byteenable[0];
    wire ctrlWr = wrOk && address == ADDR_INT_CONTROL;
    wire flagRd = read && !waitrequest && address == ADDR_FLAGS;
    wire pulseM = ctrlR[CTRL_PULSE_BIT];
    wire pinAct = intPinOe && (intPinOut == ctrlR[CTRL_POLARITY_BIT]);
    wire dateOk = dateR[7] || currentDate == dateR[5:0];
    wire alarmHit = compareStrobe && otherFieldsMatch && dateOk;
    wire trigEv = (watchdogTimeout && ctrlR[7]) || (alarmHit && ctrlR[6]);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrlR <= 8'h00;
            dateR <= 8'h80;
            quietR <= 8'hff;
        end else begin
            if (ctrlWr) ctrlR <= writedata[7:0];
            if (wrOk && address == ADDR_ALARM_DATE) dateR <= writedata[7:0];
            // saturate so a long idle never wraps back into the window
            if (trigEv) quietR <= 8'h00;
            else if (quietR != 8'hff) quietR <= quietR + 8'h01;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_alarm_pin; alarmHit && dateR[7] && ctrlR[6] && !ctrlWr |=> pinAct; endproperty
    a_alarm_pin: assert property (p_alarm_pin) else $error("alarm left pin idle");
    property p_no_pin; !pinAct && !trigEv && !ctrlWr |=> !pinAct; endproperty
    a_no_pin: assert property (p_no_pin) else $error("pin rose without enabled event");
    property p_od; !ctrlR[CTRL_POLARITY_BIT] |-> !(intPinOe && intPinOut); endproperty
    a_od: assert property (p_od) else $error("open drain drove high");
    property p_pulse_min; $rose(pinAct) && pulseM && !ctrlWr |=> pinAct [*8]; endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
    property p_pulse_end; pulseM && quietR > PULSE_CYCLES + 1 |-> !pinAct; endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");
    property p_hold; !pulseM && pinAct && !flagRd && !ctrlWr |=> pinAct; endproperty
    a_hold: assert property (p_hold) else $error("level dropped early");
    property p_release; !pulseM && flagRd && !trigEv && !ctrlWr |=> !pinAct; endproperty
    a_release: assert property (p_release) else $error("flags read kept pin");
    property p_wd_pin; watchdogTimeout && ctrlR[7] && !ctrlWr |=> pinAct; endproperty
    a_wd_pin: assert property (p_wd_pin) else $error("timeout left pin idle");
    property p_date; alarmHit && !dateR[7] && ctrlR[6] && !ctrlWr |=> pinAct; endproperty
    a_date: assert property (p_date) else $error("date match left pin idle");
    c_pulse: cover property (pulseM && $rose(pinAct));
    c_release: cover property (flagRd && pinAct);
    c_od: cover property (!ctrlR[CTRL_POLARITY_BIT] && pinAct);
endmodule : rtc_irq_output_sva

bind rtc_irq_output rtc_irq_output_sva #(.PULSE_CYCLES(PULSE_CYCLES)) sva (.core_clk, .resetn,
    .address, .read, .write, .writedata, .byteenable, .waitrequest, .compareStrobe,
    .otherFieldsMatch, .currentDate, .watchdogTimeout, .intPinOut, .intPinOe);

/* File: host_model.sv */
`timescale 1ns/1ns
module host_model
    import rtc_irq_pkg::*;
(
    input wire logic core_clk,
    input wire logic waitrequest,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic intPinOut,
    input wire logic intPinOe,
    output logic [ADDR_W-1:0] address,
    output logic read,
    output logic write,
    output logic [DATA_W-1:0] writedata,
    output logic [3:0] byteenable,
    output logic pinWire
);
    // released pin floats to the pull-up
    assign pinWire = intPinOe ? intPinOut : 1'b1;
    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'hf;
    end
    task automatic busOp(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                         output logic [DATA_W-1:0] q);
        @(posedge core_clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        read <= rd;
        write <= !rd;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : busOp
endmodule : host_model

/* File: tb_rtc_irq_output_alarm_date.sv */
`timescale 1ns/1ns
`define CHK(a, b, m) begin nChecks++; if ((a) !== (b)) begin numErrors++; \
    $display("mismatch %0t %s", $time, m); end end
module tb_rtc_irq_output_alarm_date;
    import rtc_irq_pkg::*;
    logic core_clk = 0, resetn = 0, compareStrobe = 0, otherFieldsMatch = 0, watchdogTimeout = 0;
    logic [5:0] currentDate = 6'h00;
    logic [ADDR_W-1:0] address;
    logic read, write, waitrequest, intPinOut, intPinOe, irq, pinWire;
    logic [DATA_W-1:0] writedata, readdata, q;
    logic [3:0] byteenable;
    int numErrors = 0, nChecks = 0, cycles = 0;
    always #4 core_clk = ~core_clk;
    // short pulse keeps the run small
    rtc_irq_output #(.PULSE_CYCLES(20)) uut (.core_clk, .resetn, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest, .compareStrobe, .otherFieldsMatch,
        .currentDate, .watchdogTimeout, .intPinOut, .intPinOe, .irq);
    host_model host (.core_clk, .waitrequest, .readdata, .intPinOut, .intPinOe, .address,
        .read, .write, .writedata, .byteenable, .pinWire);
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        host.busOp(1'b0, a, d, q);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string m);
        host.busOp(1'b1, a, 8'h00, q);
        `CHK(q, {24'h00_0000, e}, m)
    endtask : rd
    task automatic ev(input logic wd, input logic [5:0] day);
        @(posedge core_clk);
        currentDate <= day;
        otherFieldsMatch <= 1'b1;
        compareStrobe <= !wd;
        watchdogTimeout <= wd;
        @(posedge core_clk);
        compareStrobe <= 1'b0;
        watchdogTimeout <= 1'b0;
        @(negedge core_clk);
    endtask : ev
    task automatic tRegs;
        rd(ADDR_ALARM_DATE, 8'h80, "date reset");
        rd(ADDR_INT_CONTROL, 8'h00, "ctrl reset");
        wr(ADDR_ALARM_DATE, 8'h25);
        rd(ADDR_ALARM_DATE, 8'h25, "date rw");
        wr(21'h00_0010, 8'h5a);
        rd(21'h00_0010, 8'h00, "unmapped");
    endtask : tRegs
    task automatic tAlarm;
        ev(1'b0, 6'h25);
        `CHK(pinWire, 1'b1, "disabled alarm drove pin")
        rd(ADDR_FLAGS, 8'h40, "alarm flag");
        wr(ADDR_FLAGS, 8'hc0);
        wr(ADDR_INT_CONTROL, 8'h40);
        ev(1'b0, 6'h24);
        `CHK(pinWire, 1'b1, "date mismatch drove pin")
        ev(1'b0, 6'h25);
        `CHK(pinWire, 1'b0, "alarm pin low")
        repeat (30) @(negedge core_clk);
        `CHK(pinWire, 1'b0, "level not held")
        rd(ADDR_FLAGS, 8'h40, "flag with pin");
        @(negedge core_clk);
        `CHK(pinWire, 1'b1, "read kept pin")
    endtask : tAlarm
    task automatic tPulse;
        wr(ADDR_ALARM_DATE, 8'h80);
        wr(ADDR_INT_CONTROL, 8'hcc);
        ev(1'b0, 6'h11);
        `CHK(pinWire, 1'b1, "push-pull high")
        repeat (15) @(negedge core_clk);
        ev(1'b1, 6'h11);
        repeat (18) @(negedge core_clk);
        `CHK(pinWire, 1'b1, "retrigger")
        repeat (4) @(negedge core_clk);
        `CHK(intPinOe & intPinOut, 1'b0, "pulse end")
        `CHK(pinWire, 1'b0, "push-pull idle not low")
        rd(ADDR_FLAGS, 8'hc0, "both flags");
        wr(ADDR_FLAGS, 8'hc0);
        wr(ADDR_INT_CONTROL, 8'h0c);
        ev(1'b1, 6'h11);
        `CHK(intPinOe & intPinOut, 1'b0, "wd disabled")
        rd(ADDR_FLAGS, 8'h80, "wd flag");
    endtask : tPulse
    task automatic tIrq;
        wr(ADDR_IRQ_MASK, 8'h00);
        @(negedge core_clk);
        `CHK(irq, 1'b0, "masked irq")
        wr(ADDR_IRQ_MASK, 8'h02);
        @(negedge core_clk);
        `CHK(irq, 1'b1, "unmasked irq")
        wr(ADDR_IRQ_STATUS, 8'h02);
        @(negedge core_clk);
        `CHK(irq, 1'b0, "cleared irq")
    endtask : tIrq
    task automatic closeOut;
        if (numErrors == 0 && nChecks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : closeOut
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            closeOut();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        tRegs();
        tAlarm();
        tPulse();
        tIrq();
        closeOut();
    end
endmodule : tb_rtc_irq_output_alarm_date
